//--- nvma_params.svh
// register offsets, field positions and timing counts of the nonvolatile access block
`ifndef NVMA_PARAMS_SVH
`define NVMA_PARAMS_SVH
// register offsets (nine-bit special function register space)
`define NVMA_OFF_DATA_LO 9'h10C
`define NVMA_OFF_ADDR_LO 9'h10D
`define NVMA_OFF_DATA_HI 9'h10E
`define NVMA_OFF_ADDR_HI 9'h10F
`define NVMA_OFF_CTRL 9'h18C
`define NVMA_OFF_UNLOCK 9'h18D
`define NVMA_OFF_IRQ_FLAGS 9'h00D
// control register field positions
`define NVMA_BIT_RD 0
`define NVMA_BIT_WR 1
`define NVMA_BIT_WRITE_ENABLE_BIT 2
`define NVMA_BIT_WRITE_ERROR_FLAG 3
`define NVMA_BIT_SEL 7
// write done flag position in the peripheral flag register
`define NVMA_BIT_DONE 4
// unlock key bytes
`define NVMA_KEY_FIRST 8'h55
`define NVMA_KEY_SECOND 8'hAA
// memory geometry
`define NVMA_EE_DEPTH 64
`define NVMA_PM_DEPTH 2048
// program read fetch latency in cycles
`define NVMA_PM_READ_CYCLES 2
// write timing: erase and program phases in microseconds
`define NVMA_ERASE_US 2
`define NVMA_PROG_US 2
`define NVMA_CLK_MHZ 100
`define NVMA_ERASE_CYC (`NVMA_ERASE_US * `NVMA_CLK_MHZ)
`define NVMA_PROG_CYC (`NVMA_PROG_US * `NVMA_CLK_MHZ)
`endif

//--- nvma_pkg.sv
// types shared by the nonvolatile access block
package nvma_pkg;
  typedef enum logic [1:0] {
    NVMA_IDLE = 2'b00,
    NVMA_ERASE = 2'b01,
    NVMA_PROG = 2'b10
  } nvma_wstate_t;
  typedef enum logic [1:0] {
    NVMA_UNL_NONE = 2'b00,
    NVMA_UNL_KEY1 = 2'b01,
    NVMA_UNL_OPEN = 2'b10
  } nvma_unlock_t;
endpackage

//--- nvma_access.sv
// nonvolatile data byte and program word access controller
//
// Operation
// - select bit picks data or program memory
// - data address wraps modulo 64 bytes
// - program address 13-bit, wraps above 07FFh
// - data pair carries 14-bit program word
// - read strobe set-only, hardware clears
// - data byte ready next cycle after strobe
// - program word ready after two cycles
// - read data held until read or write
// - no write starts while enable clear
// - write strobe set-only, cleared on completion
// - erase then program, timer sets duration
// - data write runs beside execution
// - program write stalls core and fetch
// - interrupts held pending during program write
// - completion sets write done flag
// - warm reset during write sets error flag
// - warm reset keeps data, address, select
// - select bit frozen while access busy
// - unlock register only qualifies write start
// - control bits 6 to 4 read zero
// - no bulk erase reachable from software
// - 55h then AAh unlock before strobe
// - enable and strobe together start nothing
// - clearing enable never aborts write
`timescale 1ns/1ps
`default_nettype none
`include "nvma_params.svh"
module nvma_access
  import nvma_pkg::*;
(
  input wire logic clock, // core instruction clock
  input wire logic rst_n, // power-on reset, asynchronous, active low
  input wire logic warmRstReq, // external or watchdog reset request, same domain
  input wire logic [8:0] regAddr, // register address
  input wire logic [7:0] regWdata, // register write data
  input wire logic regWr, // register write strobe
  input wire logic regRd, // register read strobe
  input wire logic irqIn, // interrupt event from the core's sources
  output logic [7:0] regRdata, // read data, valid cycle after strobe
  output logic coreStall, // halts execution and program fetch
  output logic irqOut, // interrupt event released to the core
  output logic writeDoneFlag // write complete flag
);
  // ********************************************************
  // register state
  // ********************************************************
  logic [7:0] dataLo_q;
  logic [5:0] dataHi_q;
  logic [7:0] addrLo_q;
  logic [4:0] addrHi_q;
  logic memSel_q;
  logic write_enable_bit_q;
  logic wrStb_q;
  logic rdStb_q;
  logic write_error_flag_q;
  logic done_q;
  logic [1:0] rdCnt_q;
  logic wrSel_q;
  logic irqPend_q;
  nvma_wstate_t wst_q;
  nvma_unlock_t unl_q;
  logic [15:0] tmr_q;
  logic [7:0] eeMem [0:`NVMA_EE_DEPTH-1];
  logic [13:0] pmMem [0:`NVMA_PM_DEPTH-1];

  // decoded bus accesses
  logic wCtrl, wUnlock, wDataLo, wDataHi, wAddrLo, wAddrHi, wFlags;
  assign wCtrl = regWr && regAddr == `NVMA_OFF_CTRL;
  assign wUnlock = regWr && regAddr == `NVMA_OFF_UNLOCK;
  assign wDataLo = regWr && regAddr == `NVMA_OFF_DATA_LO;
  assign wDataHi = regWr && regAddr == `NVMA_OFF_DATA_HI;
  assign wAddrLo = regWr && regAddr == `NVMA_OFF_ADDR_LO;
  assign wAddrHi = regWr && regAddr == `NVMA_OFF_ADDR_HI;
  assign wFlags = regWr && regAddr == `NVMA_OFF_IRQ_FLAGS;

  logic busy;
  assign busy = rdStb_q || wrStb_q;

  // ********************************************************
  // address decode
  // ********************************************************
  // upper bits simply dropped, which gives the documented wraparound
  function automatic logic [10:0] pmIndex(input logic [4:0] hi, input logic [7:0] lo);
    pmIndex = {hi[2:0], lo};
  endfunction
  function automatic logic [5:0] eeIndex(input logic [7:0] lo);
    eeIndex = lo[5:0];
  endfunction

  // start qualifiers: enable must predate the strobe write
  logic rdStart, wrStart, wrFinish;
  assign rdStart = wCtrl && regWdata[`NVMA_BIT_RD] && !busy;
  assign wrStart = wCtrl && regWdata[`NVMA_BIT_WR] && !busy && !rdStart
    && write_enable_bit_q && unl_q == NVMA_UNL_OPEN;
  assign wrFinish = wst_q == NVMA_PROG && tmr_q == 16'h0000;

  // ********************************************************
  // unlock sequence tracker
  // ********************************************************
  // any other register write breaks the sequence, so it must be uninterrupted
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      unl_q <= NVMA_UNL_NONE;
    else if (warmRstReq)
      unl_q <= NVMA_UNL_NONE;
    else if (wUnlock && regWdata == `NVMA_KEY_FIRST)
      unl_q <= NVMA_UNL_KEY1;
    else if (wUnlock && regWdata == `NVMA_KEY_SECOND && unl_q == NVMA_UNL_KEY1)
      unl_q <= NVMA_UNL_OPEN;
    else if (regWr)
      unl_q <= NVMA_UNL_NONE;
  end

  // ********************************************************
  // control bits
  // ********************************************************
  // enable and select; select frozen while busy
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_enable_bit_q <= 1'b0;
      memSel_q <= 1'b0;
    end
    else if (warmRstReq)
      write_enable_bit_q <= 1'b0; // select kept across warm reset
    else if (wCtrl)
    begin
      write_enable_bit_q <= regWdata[`NVMA_BIT_WRITE_ENABLE_BIT]; // clearing does not touch the write
      if (!busy)
        memSel_q <= regWdata[`NVMA_BIT_SEL];
    end
  end

  // read strobe and fetch counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdStb_q <= 1'b0;
      rdCnt_q <= 2'b00;
    end
    else if (warmRstReq)
    begin
      rdStb_q <= 1'b0;
      rdCnt_q <= 2'b00;
    end
    else if (rdStart)
    begin
      rdStb_q <= 1'b1;
      // a select written beside the strobe already steers this read
      rdCnt_q <= regWdata[`NVMA_BIT_SEL] ? 2'(`NVMA_PM_READ_CYCLES) : 2'b01;
    end
    else if (rdStb_q)
    begin
      rdCnt_q <= rdCnt_q - 2'b01;
      if (rdCnt_q == 2'b01)
        rdStb_q <= 1'b0; // hardware clear
    end
  end

  // ********************************************************
  // write sequencer
  // ********************************************************
  // the timer, not the bus, sets the erase and program lengths
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wst_q <= NVMA_IDLE;
      tmr_q <= 16'h0000;
      wrStb_q <= 1'b0;
      wrSel_q <= 1'b0;
    end
    else if (warmRstReq)
    begin
      wst_q <= NVMA_IDLE;
      tmr_q <= 16'h0000;
      wrStb_q <= 1'b0;
    end
    else
    begin
      case (wst_q)
        NVMA_IDLE:
        begin
          if (wrStart)
          begin
            wst_q <= NVMA_ERASE;
            tmr_q <= 16'(`NVMA_ERASE_CYC - 1);
            wrStb_q <= 1'b1;
            wrSel_q <= regWdata[`NVMA_BIT_SEL];
          end
        end
        NVMA_ERASE:
        begin
          if (tmr_q == 16'h0000)
          begin
            wst_q <= NVMA_PROG;
            tmr_q <= 16'(`NVMA_PROG_CYC - 1);
          end
          else
            tmr_q <= tmr_q - 16'h0001;
        end
        NVMA_PROG:
        begin
          if (tmr_q == 16'h0000)
          begin
            wst_q <= NVMA_IDLE;
            wrStb_q <= 1'b0;
          end
          else
            tmr_q <= tmr_q - 16'h0001;
        end
        default:
        begin
          wst_q <= NVMA_IDLE;
          wrStb_q <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // memory arrays
  // ********************************************************
  // only single locations are ever erased; no bulk path exists
  always_ff @(posedge clock)
  begin
    if (wst_q == NVMA_ERASE && tmr_q == 16'h0000 && !warmRstReq)
    begin
      if (wrSel_q)
        pmMem[pmIndex(addrHi_q, addrLo_q)] <= 14'h3FFF;
      else
        eeMem[eeIndex(addrLo_q)] <= 8'hFF;
    end
    else if (wrFinish && !warmRstReq)
    begin
      if (wrSel_q)
        pmMem[pmIndex(addrHi_q, addrLo_q)] <= {dataHi_q, dataLo_q};
      else
        eeMem[eeIndex(addrLo_q)] <= dataLo_q;
    end
  end

  // ********************************************************
  // address and data registers
  // ********************************************************
  // warm reset leaves these alone so a cut write can be retried
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrLo_q <= 8'h00;
      addrHi_q <= 5'h00;
    end
    else if (!warmRstReq)
    begin
      if (wAddrLo)
        addrLo_q <= regWdata;
      if (wAddrHi)
        addrHi_q <= regWdata[4:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataLo_q <= 8'h00;
      dataHi_q <= 6'h00;
    end
    else if (!warmRstReq)
    begin
      if (rdStb_q && rdCnt_q == 2'b01)
      begin
        if (memSel_q)
          {dataHi_q, dataLo_q} <= pmMem[pmIndex(addrHi_q, addrLo_q)];
        else
          dataLo_q <= eeMem[eeIndex(addrLo_q)];
      end
      else
      begin
        if (wDataLo)
          dataLo_q <= regWdata;
        if (wDataHi)
          dataHi_q <= regWdata[5:0];
      end
    end
  end

  // ********************************************************
  // status flags
  // ********************************************************
  // error flag set when warm reset cuts a write; set wins over clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      write_error_flag_q <= 1'b0;
    else if (warmRstReq && wrStb_q)
      write_error_flag_q <= 1'b1;
    else if (wCtrl)
      write_error_flag_q <= regWdata[`NVMA_BIT_WRITE_ERROR_FLAG];
  end

  // done flag: completion beats a same-cycle software clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      done_q <= 1'b0;
    else if (wrFinish && !warmRstReq)
      done_q <= 1'b1;
    else if (wFlags)
      done_q <= regWdata[`NVMA_BIT_DONE];
  end

  // ********************************************************
  // stall and interrupt queueing
  // ********************************************************
  logic pmWriting;
  assign pmWriting = wrStart ? regWdata[`NVMA_BIT_SEL] : (wrStb_q && wrSel_q && !wrFinish);

  // data writes never stall; program writes halt the core until done
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coreStall <= 1'b0;
      irqPend_q <= 1'b0;
      irqOut <= 1'b0;
    end
    else if (warmRstReq)
    begin
      coreStall <= 1'b0;
      irqPend_q <= 1'b0;
      irqOut <= 1'b0;
    end
    else
    begin
      coreStall <= pmWriting;
      if (pmWriting)
      begin
        irqPend_q <= irqPend_q || irqIn;
        irqOut <= 1'b0;
      end
      else
      begin
        irqOut <= irqPend_q || irqIn; // released once stall drops
        irqPend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      writeDoneFlag <= 1'b0;
    else
      writeDoneFlag <= (wrFinish && !warmRstReq) || (wFlags ? regWdata[`NVMA_BIT_DONE] : done_q);
  end

  // ********************************************************
  // read data path
  // ********************************************************
  // unmapped addresses read as zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRd)
    begin
      case (regAddr)
        `NVMA_OFF_CTRL: regRdata <= {memSel_q, 3'b000, write_error_flag_q, write_enable_bit_q, wrStb_q, rdStb_q};
        `NVMA_OFF_DATA_LO: regRdata <= dataLo_q;
        `NVMA_OFF_DATA_HI: regRdata <= {2'b00, dataHi_q};
        `NVMA_OFF_ADDR_LO: regRdata <= addrLo_q;
        `NVMA_OFF_ADDR_HI: regRdata <= {3'b000, addrHi_q};
        `NVMA_OFF_IRQ_FLAGS: regRdata <= {3'b000, done_q, 4'h0};
        default: regRdata <= 8'h00; // unlock register reads zero too
      endcase
    end
    else
      regRdata <= 8'h00;
  end

  // ********************************************************
  // checks
  // ********************************************************
  AST_NO_WRITE_WITHOUT_ENABLE: assert property (@(posedge clock) disable iff (!rst_n)
    (wst_q == NVMA_IDLE && !write_enable_bit_q) |=> wst_q == NVMA_IDLE)
    else $error("write started with enable clear");
  AST_SAME_WRITE_NO_START: assert property (@(posedge clock) disable iff (!rst_n)
    (wCtrl && !write_enable_bit_q && wst_q == NVMA_IDLE && !warmRstReq) |=> !wrStb_q)
    else $error("enable and strobe together started a write");
  AST_EE_READ_NEXT: assert property (@(posedge clock) disable iff (!rst_n)
    (rdStart && !regWdata[`NVMA_BIT_SEL] && !warmRstReq) |=> rdStb_q ##1 !rdStb_q)
    else $error("data read not done next cycle");
  AST_PM_READ_TWO: assert property (@(posedge clock) disable iff (!rst_n)
    (rdStart && regWdata[`NVMA_BIT_SEL] && !warmRstReq) |=> rdStb_q [*2] ##1 !rdStb_q)
    else $error("program read not two cycles");
  AST_DONE_ON_FINISH: assert property (@(posedge clock) disable iff (!rst_n)
    (wrFinish && !warmRstReq) |=> done_q && !wrStb_q)
    else $error("done flag not set at completion");
  AST_ERR_ON_CUT: assert property (@(posedge clock) disable iff (!rst_n)
    (warmRstReq && wrStb_q) |=> write_error_flag_q)
    else $error("cut write did not flag error");
  AST_SEL_FROZEN: assert property (@(posedge clock) disable iff (!rst_n)
    busy |=> $stable(memSel_q))
    else $error("select changed while busy");
  AST_STALL_PM: assert property (@(posedge clock) disable iff (!rst_n)
    (wrStart && regWdata[`NVMA_BIT_SEL] && !warmRstReq) |=> coreStall)
    else $error("program write did not stall");
  AST_EE_NO_STALL: assert property (@(posedge clock) disable iff (!rst_n)
    (wrStb_q && !wrSel_q) |=> !coreStall)
    else $error("data write stalled core");
  AST_CTRL_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    $past(regRd) && $past(regAddr) == `NVMA_OFF_CTRL |-> regRdata[6:4] == 3'b000)
    else $error("unimplemented bits read nonzero");
  AST_NO_IRQ_IN_STALL: assert property (@(posedge clock) disable iff (!rst_n)
    coreStall |-> !irqOut)
    else $error("interrupt released during program write");
  AST_WAIT_UNLOCK: assert property (@(posedge clock) disable iff (!rst_n)
    (wst_q == NVMA_IDLE && unl_q != NVMA_UNL_OPEN) |=> wst_q == NVMA_IDLE)
    else $error("write started without unlock");
  COV_EE_WRITE: cover property (@(posedge clock) disable iff (!rst_n)
    wrStart && !memSel_q);
  COV_PM_WRITE: cover property (@(posedge clock) disable iff (!rst_n)
    wrStart && memSel_q);
  COV_PM_READ: cover property (@(posedge clock) disable iff (!rst_n)
    rdStart && memSel_q);
  COV_CUT_WRITE: cover property (@(posedge clock) disable iff (!rst_n)
    warmRstReq && wrStb_q);
endmodule
`default_nettype wire

//--- nvma_core_model.sv
// core-side model: raises interrupt events and checks their release around stalls
`timescale 1ns/1ps
`default_nettype none
module nvma_core_model
  import nvma_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst_n, // power-on reset, active low
  input wire logic warmRstReq, // external or watchdog reset, drops queued events
  input wire logic coreStall, // execution halted by a program write
  input wire logic irqOut, // interrupt released by the block
  output logic irqIn, // interrupt event into the block
  output var int errCount, // misplaced or late releases
  output var int relCount // releases seen
);
  int freeCnt;
  int stallCnt;
  int pend;
  int waitCnt;
  logic outPrev;
  // *************************************************************
  // event source and release checks
  // *************************************************************
  // one event deep inside each stall, one every 64 cycles elsewhere
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqIn <= 1'b0;
      freeCnt = 0;
      stallCnt = 0;
      pend = 0;
      waitCnt = 0;
      outPrev = 1'b0;
      errCount = 0;
      relCount = 0;
    end
    else if (warmRstReq === 1'b1)
    begin
      // a warm reset wipes whatever the block had queued
      irqIn <= 1'b0;
      pend = 0;
      waitCnt = 0;
      stallCnt = 0;
      outPrev = irqOut;
    end
    else
    begin
      // a release deep in a stall, or with nothing queued, is wrong
      if (irqOut === 1'b1 && outPrev !== 1'b1)
      begin
        relCount++;
        if (pend == 0 || (coreStall === 1'b1 && stallCnt > 2))
          errCount++;
        else
          pend = 0; // one release serves every event queued so far
      end
      if (irqIn === 1'b1)
        pend++;
      // a queued event must come out within a few cycles of the stall ending
      waitCnt = (pend > 0 && coreStall !== 1'b1) ? waitCnt + 1 : 0;
      if (waitCnt > 3)
        errCount++;
      irqIn <= (coreStall === 1'b1) ? (stallCnt == 50) : (freeCnt == 63);
      stallCnt = (coreStall === 1'b1) ? stallCnt + 1 : 0;
      freeCnt = (freeCnt + 1) % 64;
      outPrev = irqOut;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking testbench of the nonvolatile access block
`timescale 1ns/1ps
`default_nettype none
`include "nvma_params.svh"
module tb
  import nvma_pkg::*;
;
  logic clock;
  logic rst_n;
  logic warmRstReq;
  logic [8:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic irqIn;
  logic [7:0] regRdata;
  logic coreStall;
  logic irqOut;
  logic writeDoneFlag;
  int errCount;
  int relCount;
  int failCount = 0;
  int comparisons = 0;
  logic [7:0] expQ[$];
  string nameQ[$];
  logic rdPend = 1'b0;

  nvma_access uut (.clock(clock), .rst_n(rst_n), .warmRstReq(warmRstReq), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .irqIn(irqIn), .regRdata(regRdata),
    .coreStall(coreStall), .irqOut(irqOut), .writeDoneFlag(writeDoneFlag));
  nvma_core_model core (.clock(clock), .rst_n(rst_n), .warmRstReq(warmRstReq),
    .coreStall(coreStall), .irqOut(irqOut),
    .irqIn(irqIn), .errCount(errCount), .relCount(relCount));

  // *************************************************************
  // bus tasks and comparisons
  // *************************************************************
  task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkBit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      failCount++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  // strobes stay up until the next task call, so each request lasts one cycle
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    regAddr <= a;
    regWr <= 1'b0;
    regRd <= 1'b1;
    expQ.push_back(e);
    nameQ.push_back(n);
  endtask
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clock);
      regWr <= 1'b0;
      regRd <= 1'b0;
    end
  endtask
  task automatic unlock();
    wr(`NVMA_OFF_UNLOCK, `NVMA_KEY_FIRST);
    wr(`NVMA_OFF_UNLOCK, `NVMA_KEY_SECOND);
  endtask
  task automatic waitDone();
    int i;
    for (i = 0; i < 1000; i++)
    begin
      idle(1);
      #1;
      if (writeDoneFlag === 1'b1)
        break;
    end
    chkBit("writeDoneFlag", 1'b1, writeDoneFlag);
  endtask
  task automatic conclude();
    if (failCount == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // read data answers the cycle after the strobe; oldest note first
  always @(posedge clock)
  begin
    if (rdPend === 1'b1)
      chkByte(nameQ.pop_front(), expQ.pop_front(), regRdata);
    rdPend = regRd;
  end

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // cut a hang short at about thirteen times the expected run
  initial
  begin
    #200000;
    failCount++;
    conclude();
  end

  // *************************************************************
  // main sequence
  // *************************************************************
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] k;
    logic [13:0] w;
    logic [13:0] w2;
    rst_n = 1'b0;
    warmRstReq = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    void'($urandom(3));
    a = {2'b01, 6'($urandom())};
    d = 8'($urandom());
    k = 8'($urandom());
    w = 14'($urandom());
    w2 = ~w;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(`NVMA_OFF_CTRL, 8'h00, "ctrl reset");
    rd(`NVMA_OFF_UNLOCK, 8'h00, "unlock");
    wr(`NVMA_OFF_CTRL, 8'h70);
    rd(`NVMA_OFF_CTRL, 8'h00, "ctrl unused");
    // data write at a wrapped address, with tampering while busy
    wr(`NVMA_OFF_ADDR_LO, a);
    wr(`NVMA_OFF_DATA_LO, d);
    wr(`NVMA_OFF_IRQ_FLAGS, 8'h00);
    wr(`NVMA_OFF_CTRL, 8'h04);
    unlock();
    wr(`NVMA_OFF_CTRL, 8'h06);
    idle(5);
    wr(`NVMA_OFF_CTRL, 8'h80);
    rd(`NVMA_OFF_CTRL, 8'h02, "ctrl busy");
    #1 chkBit("coreStall", 1'b0, coreStall);
    waitDone();
    rd(`NVMA_OFF_IRQ_FLAGS, 8'h10, "flags");
    rd(`NVMA_OFF_CTRL, 8'h00, "ctrl done");
    wr(`NVMA_OFF_ADDR_LO, a & 8'h3F);
    wr(`NVMA_OFF_CTRL, 8'h01);
    idle(1);
    rd(`NVMA_OFF_DATA_LO, d, "data byte");
    rd(`NVMA_OFF_CTRL, 8'h00, "ctrl read");
    wr(`NVMA_OFF_ADDR_LO, 8'h00);
    rd(`NVMA_OFF_DATA_LO, d, "data held");
    // refused starts: no enable, enable with strobe, no key, broken key, keys swapped
    wr(`NVMA_OFF_IRQ_FLAGS, 8'h00);
    wr(`NVMA_OFF_ADDR_LO, a);
    wr(`NVMA_OFF_DATA_LO, ~d);
    wr(`NVMA_OFF_CTRL, 8'h00);
    unlock();
    wr(`NVMA_OFF_CTRL, 8'h02);
    rd(`NVMA_OFF_CTRL, 8'h00, "no enable");
    unlock();
    wr(`NVMA_OFF_CTRL, 8'h06);
    rd(`NVMA_OFF_CTRL, 8'h04, "joint enable");
    wr(`NVMA_OFF_CTRL, 8'h06);
    rd(`NVMA_OFF_CTRL, 8'h04, "no key");
    wr(`NVMA_OFF_UNLOCK, `NVMA_KEY_FIRST);
    wr(`NVMA_OFF_ADDR_LO, a);
    wr(`NVMA_OFF_UNLOCK, `NVMA_KEY_SECOND);
    wr(`NVMA_OFF_CTRL, 8'h06);
    rd(`NVMA_OFF_CTRL, 8'h04, "broken key");
    wr(`NVMA_OFF_UNLOCK, `NVMA_KEY_SECOND);
    wr(`NVMA_OFF_UNLOCK, `NVMA_KEY_FIRST);
    wr(`NVMA_OFF_CTRL, 8'h06);
    idle(450);
    rd(`NVMA_OFF_IRQ_FLAGS, 8'h00, "no write");
    wr(`NVMA_OFF_CTRL, 8'h01);
    idle(1);
    rd(`NVMA_OFF_DATA_LO, d, "data kept");
    // program write above the top address, two pad cycles after the start
    wr(`NVMA_OFF_ADDR_HI, 8'h08);
    wr(`NVMA_OFF_ADDR_LO, k);
    wr(`NVMA_OFF_DATA_LO, w[7:0]);
    wr(`NVMA_OFF_DATA_HI, {2'b11, w[13:8]});
    wr(`NVMA_OFF_IRQ_FLAGS, 8'h00);
    wr(`NVMA_OFF_CTRL, 8'h84);
    unlock();
    wr(`NVMA_OFF_CTRL, 8'h86);
    idle(2);
    #1 chkBit("coreStall", 1'b1, coreStall);
    waitDone();
    chkBit("coreStall", 1'b0, coreStall);
    rd(`NVMA_OFF_CTRL, 8'h84, "ctrl prog");
    wr(`NVMA_OFF_ADDR_HI, 8'h00);
    wr(`NVMA_OFF_CTRL, 8'h81);
    idle(2);
    rd(`NVMA_OFF_DATA_LO, w[7:0], "word low");
    rd(`NVMA_OFF_DATA_HI, {2'b00, w[13:8]}, "word high");
    // warm reset in mid program write keeps the setup for a retry
    wr(`NVMA_OFF_DATA_LO, w2[7:0]);
    wr(`NVMA_OFF_IRQ_FLAGS, 8'h00);
    wr(`NVMA_OFF_CTRL, 8'h84);
    unlock();
    wr(`NVMA_OFF_CTRL, 8'h86);
    idle(60);
    warmRstReq <= 1'b1;
    @(posedge clock);
    warmRstReq <= 1'b0;
    rd(`NVMA_OFF_CTRL, 8'h88, "ctrl warm");
    rd(`NVMA_OFF_ADDR_LO, k, "addr low");
    rd(`NVMA_OFF_ADDR_HI, 8'h00, "addr high");
    rd(`NVMA_OFF_DATA_LO, w2[7:0], "data low");
    rd(`NVMA_OFF_IRQ_FLAGS, 8'h00, "flags warm");
    #1 chkBit("coreStall", 1'b0, coreStall);
    wr(`NVMA_OFF_CTRL, 8'h80);
    rd(`NVMA_OFF_CTRL, 8'h80, "error clear");
    idle(100);
    chkBit("core events", 1'b1, errCount == 0 && relCount > 2);
    conclude();
  end
endmodule
`default_nettype wire
